/* rtl/scpi_status_register_set.sv */
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
module scpi_status_register_set #(
    parameter int QDEPTH = status_pkg::QUEUE_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [15:0] i_oper_cond,
    input wire logic [15:0] i_arm_cond,
    input wire logic [15:0] i_seq_cond,
    input wire logic [15:0] i_trig_cond,
    input wire logic i_err_push,
    input wire logic [15:0] i_err_code,
    input wire logic [4:0] i_err_class,
    output logic [3:0] o_summary
);

    localparam int W = status_pkg::REG_W;

    // ------------------------------------------------------------
    // condition input synchronisers
    // ------------------------------------------------------------
    logic [4*W-1:0] cond_s1_reg;
    logic [4*W-1:0] cond_s2_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cond_s1_reg <= '0;
            cond_s2_reg <= '0;
        end else begin
            cond_s1_reg <= {i_trig_cond, i_seq_cond, i_arm_cond, i_oper_cond};
            cond_s2_reg <= cond_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic grp_hit;
    logic [1:0] grp_idx;
    logic [11:0] fld_off;
    logic ques_hit;
    logic ctrl_hit;
    logic qnext_hit;
    logic qen_hit;
    logic qdis_hit;
    logic qcnt_hit;
    logic sum_hit;
    logic mapped;
    logic cls_pulse;
    logic preset_pulse;
    logic [31:0] qen_reg;
    logic [31:0] qen_next;
    logic [31:0] qdis_reg;
    logic [31:0] qdis_next;
    logic [31:0] rdata_mux;
    logic [15:0] q_head;
    logic [$clog2(QDEPTH+1)-1:0] q_count;

    function automatic logic field_is(input logic [11:0] off, input logic [11:0] want);
        field_is = (off == want);
    endfunction

    assign access = i_psel && i_penable;
    assign wr_acc = access && i_pwrite;
    assign rd_acc = access && !i_pwrite;
    assign grp_hit = (i_paddr < status_pkg::OFF_CTRL) && (i_paddr[1:0] == 2'b00);
    assign grp_idx = i_paddr[6:5];
    assign fld_off = {7'h00, i_paddr[4:0]};
    assign ques_hit = (i_paddr >= status_pkg::OFF_QUES_BASE) && (i_paddr <= status_pkg::OFF_QUES_LAST)
                      && (i_paddr[1:0] == 2'b00);
    assign ctrl_hit = field_is(i_paddr, status_pkg::OFF_CTRL);
    assign qnext_hit = field_is(i_paddr, status_pkg::OFF_QUEUE_NEXT);
    assign qen_hit = field_is(i_paddr, status_pkg::OFF_QUEUE_ENABLE);
    assign qdis_hit = field_is(i_paddr, status_pkg::OFF_QUEUE_DISABLE);
    assign qcnt_hit = field_is(i_paddr, status_pkg::OFF_QUEUE_COUNT);
    assign sum_hit = field_is(i_paddr, status_pkg::OFF_SUMMARY);
    assign mapped = (grp_hit && fld_off <= status_pkg::OFF_COND) || ques_hit || ctrl_hit || qnext_hit
                    || qen_hit || qdis_hit || qcnt_hit || sum_hit;
    assign cls_pulse = wr_acc && ctrl_hit && i_pwdata[status_pkg::CTRL_CLS_BIT];
    assign preset_pulse = wr_acc && ctrl_hit && i_pwdata[status_pkg::CTRL_PRESET_BIT];

    // ------------------------------------------------------------
    // register groups
    // ------------------------------------------------------------
    status_group_if #(.W(W)) gif [status_pkg::NUM_GROUPS] ();
    logic [W-1:0] grp_event [status_pkg::NUM_GROUPS];
    logic [W-1:0] grp_enable [status_pkg::NUM_GROUPS];
    logic [W-1:0] grp_ptr [status_pkg::NUM_GROUPS];
    logic [W-1:0] grp_ntr [status_pkg::NUM_GROUPS];
    logic [W-1:0] grp_cond [status_pkg::NUM_GROUPS];

    for (genvar k = 0; k < status_pkg::NUM_GROUPS; k++) begin : g_grp
        logic sel;
        assign sel = grp_hit && (grp_idx == 2'(k));
        assign gif[k].cond = cond_s2_reg[k*W +: W];
        assign gif[k].wdata = i_pwdata[W-1:0];
        assign gif[k].wr_enable = wr_acc && sel && field_is(fld_off, status_pkg::OFF_ENABLE);
        assign gif[k].wr_ptr = wr_acc && sel && field_is(fld_off, status_pkg::OFF_PTR);
        assign gif[k].wr_ntr = wr_acc && sel && field_is(fld_off, status_pkg::OFF_NTR);
        assign gif[k].rd_event = rd_acc && sel && field_is(fld_off, status_pkg::OFF_EVENT);
        assign gif[k].clear_events = cls_pulse;
        assign gif[k].preset = preset_pulse;
        assign grp_event[k] = gif[k].event_q;
        assign grp_enable[k] = gif[k].enable_q;
        assign grp_ptr[k] = gif[k].ptr_q;
        assign grp_ntr[k] = gif[k].ntr_q;
        assign grp_cond[k] = gif[k].cond_q;
        assign o_summary[k] = gif[k].summary;

        status_group #(.W(W)) u_grp (
            .i_sys_clk(i_sys_clk),
            .i_resetn(i_resetn),
            .g(gif[k])
        );
    end

    // ------------------------------------------------------------
    // error queue and its message filters
    // ------------------------------------------------------------
    always_comb begin
        qen_next = qen_reg;
        qdis_next = qdis_reg;
        if (wr_acc && qen_hit) begin
            qen_next = i_pwdata;
        end
        if (wr_acc && qdis_hit) begin
            qdis_next = i_pwdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            qen_reg <= status_pkg::QUEUE_ENABLE_DEF;
            qdis_reg <= status_pkg::QUEUE_DISABLE_DEF;
        end else begin
            qen_reg <= qen_next;
            qdis_reg <= qdis_next;
        end
    end

    error_queue #(
        .DEPTH(QDEPTH),
        .CODE_W(16),
        .CLASS_W(status_pkg::ERR_CLASS_W)
    ) u_queue (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_push(i_err_push),
        .i_code(i_err_code),
        .i_class(i_err_class),
        .i_allow(qen_reg),
        .i_block(qdis_reg),
        .i_pop(rd_acc && qnext_hit),
        .i_flush(cls_pulse),
        .o_head(q_head),
        .o_count(q_count)
    );

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_mux = '0;
        if (grp_hit) begin
            case (fld_off)
                status_pkg::OFF_EVENT: rdata_mux = {16'h0000, grp_event[grp_idx]};
                status_pkg::OFF_ENABLE: rdata_mux = {16'h0000, grp_enable[grp_idx]};
                status_pkg::OFF_PTR: rdata_mux = {16'h0000, grp_ptr[grp_idx]};
                status_pkg::OFF_NTR: rdata_mux = {16'h0000, grp_ntr[grp_idx]};
                status_pkg::OFF_COND: rdata_mux = {16'h0000, grp_cond[grp_idx]};
                default: rdata_mux = '0;
            endcase
        end else if (qnext_hit) begin
            rdata_mux = {16'h0000, q_head};
        end else if (qen_hit) begin
            rdata_mux = qen_reg;
        end else if (qdis_hit) begin
            rdata_mux = qdis_reg;
        end else if (qcnt_hit) begin
            rdata_mux = 32'(q_count);
        end else if (sum_hit) begin
            rdata_mux = {28'h000_0000, o_summary};
        end
    end

    // zero-wait slave: data taken straight from the mux in the access cycle
    assign o_prdata = rdata_mux;
    assign o_pready = 1'b1;
    assign o_pslverr = access && !mapped;

endmodule

/* rtl/status_pkg.sv */
package status_pkg;

    // ------------------------------------------------------------
    // widths and groups
    // ------------------------------------------------------------
    localparam int REG_W = 16;
    localparam int NUM_GROUPS = 4;
    localparam logic [1:0] GRP_OPER = 2'h0;
    localparam logic [1:0] GRP_ARM = 2'h1;
    localparam logic [1:0] GRP_SEQ = 2'h2;
    localparam logic [1:0] GRP_TRIG = 2'h3;

    // ------------------------------------------------------------
    // register map: group base = group * 0x20, field offset below
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_EVENT = 12'h000;
    localparam logic [11:0] OFF_ENABLE = 12'h004;
    localparam logic [11:0] OFF_PTR = 12'h008;
    localparam logic [11:0] OFF_NTR = 12'h00C;
    localparam logic [11:0] OFF_COND = 12'h010;
    localparam logic [11:0] GROUP_STRIDE = 12'h020;
    localparam logic [11:0] OFF_CTRL = 12'h080;
    localparam logic [11:0] OFF_QUEUE_NEXT = 12'h084;
    localparam logic [11:0] OFF_QUEUE_ENABLE = 12'h088;
    localparam logic [11:0] OFF_QUEUE_DISABLE = 12'h08C;
    localparam logic [11:0] OFF_QUEUE_COUNT = 12'h090;
    localparam logic [11:0] OFF_SUMMARY = 12'h094;
    localparam logic [11:0] OFF_QUES_BASE = 12'h0A0;
    localparam logic [11:0] OFF_QUES_LAST = 12'h0B0;

    // ------------------------------------------------------------
    // control register bits (write-one pulses)
    // ------------------------------------------------------------
    localparam int CTRL_CLS_BIT = 0;
    localparam int CTRL_PRESET_BIT = 1;

    // ------------------------------------------------------------
    // reset and preset values
    // ------------------------------------------------------------
    localparam logic [15:0] EVENT_RST = 16'h0000;
    localparam logic [15:0] ENABLE_DEF = 16'h0000;
    localparam logic [15:0] PTR_DEF = 16'hFFFF;
    localparam logic [15:0] NTR_DEF = 16'h0000;
    localparam logic [31:0] QUEUE_ENABLE_DEF = 32'hFFFF_FFFF;
    localparam logic [31:0] QUEUE_DISABLE_DEF = 32'h0000_0000;
    localparam logic [15:0] NO_ERROR_CODE = 16'h0000;

    // ------------------------------------------------------------
    // error queue
    // ------------------------------------------------------------
    localparam int QUEUE_DEPTH = 8;
    localparam int ERR_CLASS_W = 5;

endpackage

/* rtl/status_group_if.sv */
`timescale 1ns/1ps
interface status_group_if #(
    parameter int W = 16
);
    logic [W-1:0] cond;
    logic wr_enable;
    logic wr_ptr;
    logic wr_ntr;
    logic [W-1:0] wdata;
    logic rd_event;
    logic clear_events;
    logic preset;
    logic [W-1:0] event_q;
    logic [W-1:0] enable_q;
    logic [W-1:0] ptr_q;
    logic [W-1:0] ntr_q;
    logic [W-1:0] cond_q;
    logic summary;

    modport ctrl (
        output cond, wr_enable, wr_ptr, wr_ntr, wdata, rd_event, clear_events, preset,
        input event_q, enable_q, ptr_q, ntr_q, cond_q, summary
    );
    modport grp (
        input cond, wr_enable, wr_ptr, wr_ntr, wdata, rd_event, clear_events, preset,
        output event_q, enable_q, ptr_q, ntr_q, cond_q, summary
    );
endinterface

/* rtl/status_group.sv */
`timescale 1ns/1ps
module status_group #(
    parameter int W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    status_group_if.grp g
);

    logic [W-1:0] event_reg;
    logic [W-1:0] event_next;
    logic [W-1:0] enable_reg;
    logic [W-1:0] enable_next;
    logic [W-1:0] ptr_reg;
    logic [W-1:0] ptr_next;
    logic [W-1:0] ntr_reg;
    logic [W-1:0] ntr_next;
    logic [W-1:0] cond_reg;
    logic [W-1:0] cond_next;
    logic [W-1:0] hits;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        cond_next = g.cond;
        hits = (ptr_reg & g.cond & ~cond_reg) | (ntr_reg & ~g.cond & cond_reg);
        event_next = event_reg;
        if (g.rd_event || g.clear_events) begin
            event_next = '0;
        end
        // new edge wins over a clear in the same cycle
        event_next = event_next | hits;
        enable_next = enable_reg;
        ptr_next = ptr_reg;
        ntr_next = ntr_reg;
        if (g.preset) begin
            enable_next = W'(status_pkg::ENABLE_DEF);
            ptr_next = W'(status_pkg::PTR_DEF);
            ntr_next = W'(status_pkg::NTR_DEF);
        end else begin
            if (g.wr_enable) begin
                enable_next = g.wdata;
            end
            if (g.wr_ptr) begin
                ptr_next = g.wdata;
            end
            if (g.wr_ntr) begin
                ntr_next = g.wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            event_reg <= W'(status_pkg::EVENT_RST);
            enable_reg <= W'(status_pkg::ENABLE_DEF);
            ptr_reg <= W'(status_pkg::PTR_DEF);
            ntr_reg <= W'(status_pkg::NTR_DEF);
            cond_reg <= '0;
        end else begin
            event_reg <= event_next;
            enable_reg <= enable_next;
            ptr_reg <= ptr_next;
            ntr_reg <= ntr_next;
            cond_reg <= cond_next;
        end
    end

    assign g.event_q = event_reg;
    assign g.enable_q = enable_reg;
    assign g.ptr_q = ptr_reg;
    assign g.ntr_q = ntr_reg;
    assign g.cond_q = cond_reg;
    assign g.summary = |(event_reg & enable_reg);

endmodule

/* rtl/error_queue.sv */
`timescale 1ns/1ps
module error_queue #(
    parameter int DEPTH = 8,
    parameter int CODE_W = 16,
    parameter int CLASS_W = 5
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_push,
    input wire logic [CODE_W-1:0] i_code,
    input wire logic [CLASS_W-1:0] i_class,
    input wire logic [31:0] i_allow,
    input wire logic [31:0] i_block,
    input wire logic i_pop,
    input wire logic i_flush,
    output logic [CODE_W-1:0] o_head,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);

    localparam int CW = $clog2(DEPTH+1);

    logic [CODE_W-1:0] mem_reg [DEPTH];
    logic [CODE_W-1:0] mem_next [DEPTH];
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic accept;

    // ------------------------------------------------------------
    // newest entry at index 0; full queue drops oldest
    // ------------------------------------------------------------
    always_comb begin
        accept = i_push && i_allow[i_class] && !i_block[i_class];
        mem_next = mem_reg;
        count_next = count_reg;
        if (i_flush) begin
            count_next = '0;
        end else if (accept) begin
            if (i_pop) begin
                // popped head makes room for the new message
                mem_next[0] = i_code;
                if (count_reg == '0) begin
                    count_next = CW'(1);
                end
            end else begin
                for (int i = DEPTH - 1; i > 0; i--) begin
                    mem_next[i] = mem_reg[i-1];
                end
                mem_next[0] = i_code;
                if (count_reg != CW'(DEPTH)) begin
                    count_next = count_reg + CW'(1);
                end
            end
        end else if (i_pop && count_reg != '0) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                mem_next[i] = mem_reg[i+1];
            end
            count_next = count_reg - CW'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            count_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            count_reg <= count_next;
        end
    end

    assign o_head = (count_reg == '0) ? status_pkg::NO_ERROR_CODE : mem_reg[0];
    assign o_count = count_reg;

endmodule

/* tb/scpi_status_register_set_sva.sv */
`timescale 1ns/1ps
module scpi_status_register_set_sva (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [15:0] i_oper_cond,
    input wire logic [15:0] i_arm_cond,
    input wire logic [15:0] i_seq_cond,
    input wire logic [15:0] i_trig_cond,
    input wire logic i_err_push,
    input wire logic [15:0] i_err_code,
    input wire logic [4:0] i_err_class,
    input wire logic [3:0] o_summary
);
    // ------------------------------------------------------------
    // condition quiet counter
    // ------------------------------------------------------------
    logic [63:0] cond_prev_reg;
    logic [63:0] cond_prev_next;
    logic [2:0] stab_reg;
    logic [2:0] stab_next;
    logic acc;
    assign acc = i_psel && i_penable;
    always_comb begin
        cond_prev_next = {i_oper_cond, i_arm_cond, i_seq_cond, i_trig_cond};
        stab_next = (stab_reg == 3'h7) ? stab_reg : stab_reg + 3'h1;
        if (!i_resetn || (cond_prev_next != cond_prev_reg)) begin
            stab_next = 3'h0;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        cond_prev_reg <= cond_prev_next;
        stab_reg <= stab_next;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    a_ready_always: assert property (o_pready)
        else $error("pready low");
    a_unmapped_err: assert property (
        acc && i_paddr >= 12'h0B4 |-> o_pslverr && (i_pwrite || o_prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_ques_quiet: assert property (
        acc && i_paddr >= status_pkg::OFF_QUES_BASE && i_paddr <= status_pkg::OFF_QUES_LAST
        |-> !o_pslverr && (i_pwrite || o_prdata == 32'h0000_0000))
        else $error("questionable space not inert");
    a_upper_zero: assert property (
        acc && !i_pwrite && i_paddr < 12'h080 |-> o_prdata[31:16] == 16'h0000)
        else $error("group register upper half not zero");
    a_cond_live: assert property (
        acc && !i_pwrite && i_paddr == status_pkg::OFF_COND && stab_reg >= 3'h4
        |-> o_prdata[15:0] == i_oper_cond)
        else $error("condition read not live");
    a_read_clears: assert property (
        acc && !i_pwrite && i_paddr == status_pkg::OFF_EVENT && stab_reg >= 3'h6
        |=> !o_summary[0])
        else $error("event read did not clear");
    a_cls_clears: assert property (
        acc && i_pwrite && i_paddr == status_pkg::OFF_CTRL && i_pwdata[0] && stab_reg >= 3'h6
        |=> o_summary == 4'h0)
        else $error("clear status left events");
    a_preset_masks: assert property (
        acc && i_pwrite && i_paddr == status_pkg::OFF_CTRL && i_pwdata[1]
        |=> (o_summary == 4'h0) [*2])
        else $error("preset left enables");
    a_reset_quiet: assert property ($rose(i_resetn) |-> o_summary == 4'h0)
        else $error("summary set after reset");
endmodule

bind scpi_status_register_set scpi_status_register_set_sva scpi_status_register_set_sva_i (.*);

/* tb/apb_host_model.sv */
`timescale 1ns/1ps
module apb_host_model (
    input wire logic i_sys_clk,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [11:0] o_paddr,
    output logic [31:0] o_pwdata
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 12'h000;
        o_pwdata = 32'h0000_0000;
    end
    // ------------------------------------------------------------
    // one transfer, held until pready
    // ------------------------------------------------------------
    // host read or write, direction set by w
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge i_sys_clk);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_sys_clk);
        o_penable <= 1'b1;
        do @(posedge i_sys_clk); while (i_pready !== 1'b1);
        r = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule

/* tb/scpi_status_register_set_tb.sv */
`timescale 1ns/1ps
module scpi_status_register_set_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] cond [4];
    logic err_push = 1'b0;
    logic [15:0] err_code = 16'h0000;
    logic [4:0] err_class = 5'h00;
    logic [3:0] summary;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #12.5 sys_clk = ~sys_clk;

    scpi_status_register_set scpi_status_register_set_i (.i_sys_clk(sys_clk), .i_resetn(resetn),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_oper_cond(cond[0]),
        .i_arm_cond(cond[1]), .i_seq_cond(cond[2]), .i_trig_cond(cond[3]), .i_err_push(err_push),
        .i_err_code(err_code), .i_err_class(err_class), .o_summary(summary));
    apb_host_model apb_host_model_i (.i_sys_clk(sys_clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
        .o_pwdata(pwdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] v;
        logic ee;
        apb_host_model_i.xfer(1'b0, a, 32'h0000_0000, v, ee);
        chk(v, x);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic ee;
        apb_host_model_i.xfer(1'b1, a, d, v, ee);
    endtask
    task automatic edge_to(input int k, input logic [15:0] v);
        cond[k] <= v;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic push(input logic [15:0] c, input logic [4:0] cl);
        @(posedge sys_clk);
        err_push <= 1'b1;
        err_code <= c;
        err_class <= cl;
        @(posedge sys_clk);
        err_push <= 1'b0;
    endtask
    function automatic logic [11:0] ga(input int k, input logic [11:0] off);
        return status_pkg::GROUP_STRIDE * 12'(k) + off;
    endfunction

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        for (int k = 0; k < 4; k++) begin
            cond[k] = 16'h0000;
        end
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rd(ga(k, status_pkg::OFF_EVENT), 32'h0000_0000);
            rd(ga(k, status_pkg::OFF_ENABLE), 32'(status_pkg::ENABLE_DEF));
            rd(ga(k, status_pkg::OFF_PTR), 32'(status_pkg::PTR_DEF));
            rd(ga(k, status_pkg::OFF_NTR), 32'(status_pkg::NTR_DEF));
        end
        rd(status_pkg::OFF_QUEUE_ENABLE, status_pkg::QUEUE_ENABLE_DEF);
        rd(status_pkg::OFF_QUEUE_DISABLE, status_pkg::QUEUE_DISABLE_DEF);
        rd(status_pkg::OFF_QUEUE_COUNT, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            wr(ga(k, status_pkg::OFF_ENABLE), 32'hABCD_A5C0 | 32'(k));
            wr(ga(k, status_pkg::OFF_PTR), 32'hABCD_5A30 | 32'(k));
            wr(ga(k, status_pkg::OFF_NTR), 32'hABCD_3C00 | 32'(k));
            wr(ga(k, status_pkg::OFF_COND), 32'h0000_FFFF);
        end
        for (int k = 0; k < 4; k++) begin
            rd(ga(k, status_pkg::OFF_ENABLE), 32'h0000_A5C0 | 32'(k));
            rd(ga(k, status_pkg::OFF_PTR), 32'h0000_5A30 | 32'(k));
            rd(ga(k, status_pkg::OFF_NTR), 32'h0000_3C00 | 32'(k));
            rd(ga(k, status_pkg::OFF_COND), 32'h0000_0000);
        end
        // edges through the filters, masking and read-clear, per group
        for (int k = 0; k < 4; k++) begin
            wr(ga(k, status_pkg::OFF_ENABLE), 32'h0000_0002);
            wr(ga(k, status_pkg::OFF_PTR), 32'h0000_0002);
            wr(ga(k, status_pkg::OFF_NTR), 32'h0000_0400);
            edge_to(k, 16'h0002);
            chk(32'(summary[k]), 32'h0000_0001);
            rd(status_pkg::OFF_SUMMARY, 32'h0000_0001 << k);
            rd(ga(k, status_pkg::OFF_COND), 32'h0000_0002);
            rd(ga(k, status_pkg::OFF_EVENT), 32'h0000_0002);
            rd(ga(k, status_pkg::OFF_EVENT), 32'h0000_0000);
            @(posedge sys_clk);
            chk(32'(summary[k]), 32'h0000_0000);
            edge_to(k, 16'h0402);
            edge_to(k, 16'h0002);
            chk(32'(summary[k]), 32'h0000_0000);
            rd(ga(k, status_pkg::OFF_EVENT), 32'h0000_0400);
            edge_to(k, 16'h0000);
        end
        // clear-status, then preset keeps events
        edge_to(0, 16'h0002);
        wr(status_pkg::OFF_CTRL, 32'h0000_0001 << status_pkg::CTRL_CLS_BIT);
        rd(ga(0, status_pkg::OFF_EVENT), 32'h0000_0000);
        edge_to(0, 16'h0000);
        edge_to(0, 16'h0002);
        wr(status_pkg::OFF_CTRL, 32'h0000_0001 << status_pkg::CTRL_PRESET_BIT);
        @(posedge sys_clk);
        chk(32'(summary), 32'h0000_0000);
        rd(ga(0, status_pkg::OFF_ENABLE), 32'(status_pkg::ENABLE_DEF));
        rd(ga(0, status_pkg::OFF_PTR), 32'(status_pkg::PTR_DEF));
        rd(ga(0, status_pkg::OFF_NTR), 32'(status_pkg::NTR_DEF));
        rd(ga(0, status_pkg::OFF_EVENT), 32'h0000_0002);
        edge_to(0, 16'h0000);
        // error queue filtering and newest-first reads
        wr(status_pkg::OFF_QUEUE_ENABLE, 32'h0000_001E);
        wr(status_pkg::OFF_QUEUE_DISABLE, 32'h0000_0008);
        rd(status_pkg::OFF_QUEUE_ENABLE, 32'h0000_001E);
        rd(status_pkg::OFF_QUEUE_DISABLE, 32'h0000_0008);
        push(16'h0333, 5'h03);
        push(16'h0111, 5'h01);
        push(16'h0444, 5'h04);
        push(16'h0555, 5'h05);
        rd(status_pkg::OFF_QUEUE_COUNT, 32'h0000_0002);
        rd(status_pkg::OFF_QUEUE_NEXT, 32'h0000_0444);
        rd(status_pkg::OFF_QUEUE_NEXT, 32'h0000_0111);
        rd(status_pkg::OFF_QUEUE_NEXT, 32'(status_pkg::NO_ERROR_CODE));
        push(16'h0222, 5'h02);
        wr(status_pkg::OFF_CTRL, 32'h0000_0001 << status_pkg::CTRL_CLS_BIT);
        rd(status_pkg::OFF_QUEUE_COUNT, 32'h0000_0000);
        // questionable space and an unmapped word
        apb_host_model_i.xfer(1'b1, status_pkg::OFF_QUES_BASE, 32'hFFFF_FFFF, r, e);
        chk(32'(e), 32'h0000_0000);
        rd(status_pkg::OFF_QUES_LAST, 32'h0000_0000);
        apb_host_model_i.xfer(1'b0, 12'h0FC, 32'h0000_0000, r, e);
        chk(32'(e), 32'h0000_0001);
        chk(r, 32'h0000_0000);
        report_and_stop();
    end
endmodule
